//--- rtl/bfp_pkg.sv
// Shared constants, types and encodings for the buck fault protection control block
package bfp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OC_LIMIT_OFS    = 8'h15; // Over-current limit select
  localparam logic [7:0] OV_LEVEL_OFS    = 8'h17; // Over-voltage level select
  localparam logic [7:0] OT_LEVEL_OFS    = 8'h19; // Over-temperature level select
  localparam logic [7:0] FAULT_STAT_OFS  = 8'h1E; // Fault state, read only
  localparam logic [2:0] OC_LIMIT_RST    = 3'h2;  // 8 A (9 A adjustable)
  localparam logic [1:0] OV_LEVEL_RST    = 2'h3;  // 120 %
  localparam logic [1:0] OT_LEVEL_RST    = 2'h3;  // 145 C

  // ----------------------------------------------------------------
  // Comparison thresholds
  // ----------------------------------------------------------------
  // Current in 1/32 A steps: 4 A, 6 A, 8 A, 9 A
  localparam logic [9:0] OC_4A           = 10'h080;
  localparam logic [9:0] OC_6A           = 10'h0C0;
  localparam logic [9:0] OC_8A           = 10'h100;
  localparam logic [9:0] OC_9A           = 10'h120;
  // Feedback in percent of target: 105, 110, 115, 120, hysteresis 5
  localparam logic [7:0] OV_105          = 8'h69;
  localparam logic [7:0] OV_110          = 8'h6E;
  localparam logic [7:0] OV_115          = 8'h73;
  localparam logic [7:0] OV_120          = 8'h78;
  localparam logic [7:0] OV_HYST         = 8'h05;
  // Temperature in degrees C, 9-bit signed: 75, 85, 125, 145, hysteresis 20
  localparam logic [8:0] OT_75           = 9'h04B;
  localparam logic [8:0] OT_85           = 9'h055;
  localparam logic [8:0] OT_125          = 9'h07D;
  localparam logic [8:0] OT_145          = 9'h091;
  localparam logic [8:0] OT_HYST         = 9'h014;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TON_MIN_NS     = 30;
  localparam int TOFF_MIN_NS    = 120;
  localparam int OV_DELAY_NS    = 5000;
  localparam int HICCUP_TIME_US = 1000;
  // Least times round up to whole cycles; the on-time never below one
  localparam int TON_MIN_CYC    = ((TON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                  ((TON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int TOFF_MIN_CYC   = (TOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OV_DELAY_CYC   = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_CYC     = (HICCUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Protection state, one-hot
  typedef enum logic [5:0] {
    ST_OFF      = 6'h01,
    ST_RUN      = 6'h02,
    ST_OC_DRAIN = 6'h04,
    ST_HICCUP   = 6'h08,
    ST_OV_LATCH = 6'h10,
    ST_OT_SHUT  = 6'h20
  } bfp_state_t;

  // Drive bundle toward the power stage
  typedef struct packed {
    logic hs_on;       // High-side switch gate
    logic ls_on;       // Low-side switch gate
    logic ss_reset;    // Pull soft-start ramp to zero
    logic good;        // Output good flag
    logic ldo_en;      // Internal linear regulator run
  } bfp_drive_t;

  // Strap decode result
  typedef struct packed {
    logic       valid;     // Strap has been captured
    logic       freq_shift; // Switching frequency shifted by 300 kHz
    logic [2:0] offset;    // Address offset 0..7
  } bfp_strap_t;

endpackage

//--- rtl/bfp_fault_ctrl.sv
// Fault protection and switching-limit control for a synchronous step-down regulator
//
// Overview of operation
// - Over-current limit: 3-bit code, 4/6/8(9) A
// - Low-side current above limit raises over-current
// - Over-current drops good flag, resets soft-start
// - Low-side stays on until current reaches zero
// - Hiccup holds both switches off for blanking
// - Retry after blanking, repeat while fault persists
// - Over-voltage needs feedback high over 5 us
// - Over-voltage level: 2-bit code, 105..120 percent
// - Over-voltage: high-side off, good low, low-side on
// - Over-voltage latch cleared only by supply/enable
// - Low-side off below threshold less 5 percent
// - Over-temperature level: 2-bit, 75..145 C
// - Over-temperature: both off, soft-start reset, regulator on
// - Auto restart 20 C below temperature limit
// - High-side pulse at least 30 ns, minimum at start-up
// - High-side off at least 120 ns, current sampled then
// - Enable starts regulation, deassertion stops switching
// - Strap gives offset 0..7 and frequency shift
// - Over-current and over-voltage active during soft-start
module bfp_fault_ctrl #(
  parameter bit          ADJ_VARIANT   = 1'b0,            // Adjustable variant: code 2 = 9 A
  parameter int unsigned HICCUP_CYCLES = bfp_pkg::HICCUP_CYC // Hiccup blanking length
) (
  input  wire logic               CLK_SYS_I,       // 25 MHz system clock
  input  wire logic               RESETN_I,        // Asynchronous reset, active low
  input  wire logic               EN_I,            // Enable pin above threshold
  input  wire logic               SUPPLY_OK_I,     // Internal supply above lockout
  input  wire logic               PWM_REQ_I,       // Modulator asks for high-side on
  input  wire logic               MIN_PULSE_I,     // Start-up, output very low
  input  wire logic               PG_LEVEL_OK_I,   // Output inside good window
  input  wire logic [9:0]         LS_CURRENT_I,    // Low-side current, 1/32 A steps
  input  wire logic [7:0]         FB_PCT_I,        // Feedback in percent of target
  input  wire logic [7:0]         TEMP_I,          // Die temperature, signed degrees C
  input  wire logic [3:0]         STRAP_CODE_I,    // Strap detector resistor index
  input  wire logic               STRAP_VALID_I,   // Strap detector result ready
  input  wire logic [7:0]         REG_ADDR_I,      // Register address
  input  wire logic [7:0]         REG_WDATA_I,     // Register write data
  input  wire logic               REG_WR_I,        // Register write strobe
  input  wire logic               REG_RD_I,        // Register read strobe
  output      logic [7:0]         REG_RDATA_O,     // Register read data
  output      bfp_pkg::bfp_drive_t DRIVE_O,        // Power stage drive bundle
  output      bfp_pkg::bfp_strap_t STRAP_O         // Decoded strap
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [7:0] TON_LAST  = 8'(bfp_pkg::TON_MIN_CYC - 1);  // Last forced on-cycle
  localparam logic [7:0] TOFF_LAST = 8'(bfp_pkg::TOFF_MIN_CYC - 1); // Last forced off-cycle
  localparam logic [7:0] OV_LAST   = 8'(bfp_pkg::OV_DELAY_CYC - 1); // Qualification end
  localparam logic [23:0] HIC_LAST = 24'(HICCUP_CYCLES - 1);        // Blanking end

  logic [2:0]          oc_sel;        // Over-current limit code
  logic [1:0]          ov_sel;        // Over-voltage level code
  logic [1:0]          ot_sel;        // Over-temperature level code
  logic [9:0]          oc_limit;      // Selected current limit
  logic [7:0]          ov_limit;      // Selected feedback limit
  logic [8:0]          ot_limit;      // Selected temperature limit
  logic [8:0]          temp_s;        // Sign-extended temperature
  logic [5:0]          raw_cmp;       // Unsynchronised compare results
  logic [5:0]          sync1;         // First synchroniser stage
  logic [5:0]          sync2;         // Second synchroniser stage
  logic                oc_over;       // Current above limit
  logic                ls_zero;       // Current decayed to zero
  logic                ov_over;       // Feedback above level
  logic                ov_below;      // Feedback below level less hysteresis
  logic                ot_over;       // Temperature above limit
  logic                ot_cool;       // Temperature back at or below limit less hysteresis
  logic                run;           // Enable and supply both good
  logic [7:0]          ov_cnt;        // Over-voltage qualification counter
  logic                ov_fault;      // Qualified over-voltage
  logic [23:0]         hic_cnt;       // Hiccup blanking counter
  bfp_pkg::bfp_state_t state;         // Protection state
  bfp_pkg::bfp_state_t next_state;    // Next protection state
  logic                hs_q;          // High-side gate flop
  logic [7:0]          on_cnt;        // Cycles since high-side on
  logic [7:0]          off_cnt;       // Cycles since high-side off
  logic                oc_hit;        // Over-current sampled in off interval

  // ----------------------------------------------------------------
  // Threshold decode
  // ----------------------------------------------------------------
  // Pure lookups on the live fields, so a write acts at once
  always_comb begin
    unique case (oc_sel)
      3'h0:    oc_limit = bfp_pkg::OC_4A;
      3'h1:    oc_limit = bfp_pkg::OC_6A;
      default: oc_limit = ADJ_VARIANT ? bfp_pkg::OC_9A : bfp_pkg::OC_8A; // Unused codes act as 2
    endcase
    unique case (ov_sel)
      2'h0:    ov_limit = bfp_pkg::OV_105;
      2'h1:    ov_limit = bfp_pkg::OV_110;
      2'h2:    ov_limit = bfp_pkg::OV_115;
      default: ov_limit = bfp_pkg::OV_120;
    endcase
    unique case (ot_sel)
      2'h0:    ot_limit = bfp_pkg::OT_75;
      2'h1:    ot_limit = bfp_pkg::OT_85;
      2'h2:    ot_limit = bfp_pkg::OT_125;
      default: ot_limit = bfp_pkg::OT_145;
    endcase
  end

  // Compare results before synchronisation
  assign temp_s     = {TEMP_I[7], TEMP_I};
  assign raw_cmp[0] = LS_CURRENT_I > oc_limit;
  assign raw_cmp[1] = LS_CURRENT_I == 10'h000;
  assign raw_cmp[2] = FB_PCT_I > ov_limit;
  assign raw_cmp[3] = FB_PCT_I < (ov_limit - bfp_pkg::OV_HYST);
  assign raw_cmp[4] = $signed(temp_s) > $signed(ot_limit);
  assign raw_cmp[5] = $signed(temp_s) <= $signed(ot_limit - bfp_pkg::OT_HYST);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Two flops per compare bit; only sync2 is read by the logic
  generate
    for (genvar i = 0; i < 6; i++) begin : g_sync
      always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end else begin
          sync1[i] <= raw_cmp[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  assign oc_over  = sync2[0];
  assign ls_zero  = sync2[1];
  assign ov_over  = sync2[2];
  assign ov_below = sync2[3];
  assign ot_over  = sync2[4];
  assign ot_cool  = sync2[5];
  assign run      = EN_I & SUPPLY_OK_I;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes store only the documented field; upper bits stay zero
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      oc_sel <= bfp_pkg::OC_LIMIT_RST;
      ov_sel <= bfp_pkg::OV_LEVEL_RST;
      ot_sel <= bfp_pkg::OT_LEVEL_RST;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == bfp_pkg::OC_LIMIT_OFS) begin
        oc_sel <= REG_WDATA_I[2:0];
      end
      if (REG_ADDR_I == bfp_pkg::OV_LEVEL_OFS) begin
        ov_sel <= REG_WDATA_I[1:0];
      end
      if (REG_ADDR_I == bfp_pkg::OT_LEVEL_OFS) begin
        ot_sel <= REG_WDATA_I[1:0];
      end
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        bfp_pkg::OC_LIMIT_OFS:   REG_RDATA_O <= {5'h00, oc_sel};
        bfp_pkg::OV_LEVEL_OFS:   REG_RDATA_O <= {6'h00, ov_sel};
        bfp_pkg::OT_LEVEL_OFS:   REG_RDATA_O <= {6'h00, ot_sel};
        bfp_pkg::FAULT_STAT_OFS: REG_RDATA_O <= {2'h0, state};
        default:                 REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Over-voltage qualification
  // ----------------------------------------------------------------
  // Counts only while feedback stays high; any dip restarts it
  // Runs whenever enabled, so the soft-start ramp is covered too
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ov_cnt <= 8'h00;
    end else if (!ov_over || !run) begin
      ov_cnt <= 8'h00;
    end else if (ov_cnt != OV_LAST) begin
      ov_cnt <= ov_cnt + 8'h01;
    end
  end

  assign ov_fault = ov_over && (ov_cnt == OV_LAST);

  // ----------------------------------------------------------------
  // Hiccup blanking counter
  // ----------------------------------------------------------------
  // Long count; the parameter lets a simulation shorten it
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hic_cnt <= 24'h000000;
    end else if (state != bfp_pkg::ST_HICCUP) begin
      hic_cnt <= 24'h000000;
    end else if (hic_cnt != HIC_LAST) begin
      hic_cnt <= hic_cnt + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Protection state machine
  // ----------------------------------------------------------------
  // Current is only trusted while the low-side conducts
  assign oc_hit = oc_over && (state == bfp_pkg::ST_RUN) && !hs_q;

  // Priority: enable loss, over-voltage, over-temperature, over-current
  always_comb begin
    next_state = state;
    unique case (state)
      bfp_pkg::ST_OFF: begin
        if (run) next_state = bfp_pkg::ST_RUN;
      end
      bfp_pkg::ST_RUN: begin
        if (!run)          next_state = bfp_pkg::ST_OFF;
        else if (ov_fault) next_state = bfp_pkg::ST_OV_LATCH;
        else if (ot_over)  next_state = bfp_pkg::ST_OT_SHUT;
        else if (oc_hit)   next_state = bfp_pkg::ST_OC_DRAIN;
      end
      bfp_pkg::ST_OC_DRAIN: begin
        if (!run)          next_state = bfp_pkg::ST_OFF;
        else if (ov_fault) next_state = bfp_pkg::ST_OV_LATCH;
        else if (ls_zero)  next_state = bfp_pkg::ST_HICCUP;
      end
      bfp_pkg::ST_HICCUP: begin
        if (!run)                   next_state = bfp_pkg::ST_OFF;
        else if (hic_cnt == HIC_LAST) next_state = bfp_pkg::ST_RUN; // Retry
      end
      bfp_pkg::ST_OV_LATCH: begin
        if (!run) next_state = bfp_pkg::ST_OFF;                // Only exit
      end
      bfp_pkg::ST_OT_SHUT: begin
        if (!run)         next_state = bfp_pkg::ST_OFF;
        else if (ov_fault) next_state = bfp_pkg::ST_OV_LATCH;
        else if (ot_cool) next_state = bfp_pkg::ST_RUN;
      end
      default: next_state = bfp_pkg::ST_OFF;                   // Illegal code recovers
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= bfp_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // High-side pulse timing
  // ----------------------------------------------------------------
  // Minimum on and off widths; a fault kills the pulse at once, since
  // protection outranks the width limits
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hs_q    <= 1'b0;
      on_cnt  <= 8'h00;
      off_cnt <= 8'h00;
    end else if (next_state != bfp_pkg::ST_RUN) begin
      hs_q    <= 1'b0;
      on_cnt  <= 8'h00;
      off_cnt <= 8'h00;
    end else if (hs_q) begin
      // Release when the request ends, or at once in start-up mode
      if ((on_cnt >= TON_LAST) && (!PWM_REQ_I || MIN_PULSE_I)) begin
        hs_q    <= 1'b0;
        off_cnt <= 8'h00;
      end else if (on_cnt != 8'hFF) begin
        on_cnt <= on_cnt + 8'h01;
      end
    end else begin
      if ((off_cnt >= TOFF_LAST) && PWM_REQ_I) begin
        hs_q   <= 1'b1;
        on_cnt <= 8'h00;
      end else if (off_cnt != 8'hFF) begin
        off_cnt <= off_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  // Registered from next_state so every gate change is glitch free
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DRIVE_O <= '0;
    end else begin
      DRIVE_O.ldo_en   <= 1'b1;                                    // Never stopped
      DRIVE_O.hs_on    <= (next_state == bfp_pkg::ST_RUN) && hs_q;
      unique case (next_state)
        bfp_pkg::ST_RUN: begin
          DRIVE_O.ls_on    <= !hs_q;                               // Complementary
          DRIVE_O.ss_reset <= 1'b0;
          DRIVE_O.good     <= PG_LEVEL_OK_I;
        end
        bfp_pkg::ST_OC_DRAIN: begin
          DRIVE_O.ls_on    <= 1'b1;
          DRIVE_O.ss_reset <= 1'b1;
          DRIVE_O.good     <= 1'b0;
        end
        bfp_pkg::ST_OV_LATCH: begin
          DRIVE_O.ls_on    <= !ov_below;
          DRIVE_O.ss_reset <= 1'b1;
          DRIVE_O.good     <= 1'b0;
        end
        default: begin
          DRIVE_O.ls_on    <= 1'b0;
          DRIVE_O.ss_reset <= 1'b1;
          DRIVE_O.good     <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // Captured once after reset; low eight indices keep nominal frequency,
  // upper eight repeat the offsets shifted by 300 kHz
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      STRAP_O <= '0;
    end else if (STRAP_VALID_I && !STRAP_O.valid) begin
      STRAP_O.valid      <= 1'b1;
      STRAP_O.freq_shift <= STRAP_CODE_I[3];
      STRAP_O.offset     <= STRAP_CODE_I[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_oc_drain_entry: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    (state == bfp_pkg::ST_RUN) && run && !ov_fault && !ot_over && oc_hit
    |=> state == bfp_pkg::ST_OC_DRAIN)
    else $error("over-current not taken");

  a_oc_drain_out: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    state == bfp_pkg::ST_OC_DRAIN |=> !DRIVE_O.good && DRIVE_O.ss_reset)
    else $error("good flag or ramp not pulled during over-current");

  a_drain_ls_on: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    (state == bfp_pkg::ST_OC_DRAIN) && !ls_zero && run && !ov_fault
    |=> (state == bfp_pkg::ST_OC_DRAIN) && DRIVE_O.ls_on)
    else $error("low-side released before current reached zero");

  a_hiccup_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    $rose(state == bfp_pkg::ST_HICCUP) && run
    |=> (!DRIVE_O.hs_on && !DRIVE_O.ls_on)[*8])
    else $error("switch on during hiccup blanking");

  a_hiccup_retry: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    (state == bfp_pkg::ST_HICCUP) && run && (hic_cnt == HIC_LAST)
    |=> state == bfp_pkg::ST_RUN)
    else $error("no restart after blanking");

  a_ov_qualify: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    $rose(ov_fault) |-> $past(ov_over, 124) && ov_over)
    else $error("over-voltage qualified too early");

  a_ov_hs_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    state == bfp_pkg::ST_OV_LATCH |=> !DRIVE_O.hs_on && !DRIVE_O.good)
    else $error("high-side or good flag on in over-voltage latch");

  a_ov_latched: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    (state == bfp_pkg::ST_OV_LATCH) && run |=> state == bfp_pkg::ST_OV_LATCH)
    else $error("over-voltage latch left while enabled");

  a_ov_ls_release: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    (state == bfp_pkg::ST_OV_LATCH) && run && ov_below |=> !DRIVE_O.ls_on)
    else $error("low-side kept on below hysteresis");

  a_ot_restart: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    (state == bfp_pkg::ST_OT_SHUT) && run && !ov_fault && ot_cool
    |=> state == bfp_pkg::ST_RUN)
    else $error("no restart after cooling");

  a_min_off_time: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    $fell(hs_q) |-> !hs_q[*3])
    else $error("high-side off interval too short");

  a_enable_stop: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    !run |=> !DRIVE_O.hs_on && !DRIVE_O.ls_on)
    else $error("switching after enable loss");

endmodule

//--- tb/bfp_stage_model.sv
// Behavioural power stage: low-side current raised by a short, drained while on
module bfp_stage_model (
  input  wire logic       clk_i,    // System clock
  input  wire logic       rst_n_i,  // Reset, active low
  input  wire logic       short_i,  // Output short asked for by the bench
  input  wire logic       ls_on_i,  // Low-side gate from the design
  output logic      [9:0] cur_o     // Low-side current, 1/32 A steps
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Current ramp
  // ----------------------------------------------------------------
  // No current without a conducting low side; a slow drain exercises the drain wait
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cur_o <= 10'h000;
    else if (!ls_on_i) cur_o <= 10'h000;
    else if (short_i) cur_o <= 10'h081;
    else if (cur_o > 10'h008) cur_o <= cur_o - 10'h008;
    else cur_o <= 10'h000;
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the fault protection control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, en = 1'b0, sok = 1'b1, pwm = 1'b0, minp = 1'b0;
  logic       pgok = 1'b1, shrt = 1'b0, sv = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [9:0] cur;
  logic [7:0] fb = 8'h64, tmp = 8'h19, adr = 8'h00, wd = 8'h00, rdat, v;
  logic [3:0] sc = 4'h0;
  int         miscompares = 0, check_count = 0, n = 0;
  bfp_pkg::bfp_drive_t drv;
  bfp_pkg::bfp_strap_t stp;
  // Register table: three thresholds and one unmapped place
  logic [7:0] ofs [4] = '{8'h15, 8'h17, 8'h19, 8'h00};
  logic [7:0] dfl [4] = '{8'h02, 8'h03, 8'h03, 8'h00};
  always #20 clk = ~clk;
  bfp_stage_model stage (.clk_i(clk), .rst_n_i(rst_n), .short_i(shrt), .ls_on_i(drv.ls_on),
    .cur_o(cur));
  bfp_fault_ctrl #(.HICCUP_CYCLES(20)) uut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .EN_I(en),
    .SUPPLY_OK_I(sok), .PWM_REQ_I(pwm), .MIN_PULSE_I(minp), .PG_LEVEL_OK_I(pgok),
    .LS_CURRENT_I(cur), .FB_PCT_I(fb), .TEMP_I(tmp), .STRAP_CODE_I(sc), .STRAP_VALID_I(sv),
    .REG_ADDR_I(adr), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
    .DRIVE_O(drv), .STRAP_O(stp));
  // Field width of each place; unmapped reads back zero
  function automatic logic [7:0] fld(logic [7:0] a, logic [7:0] d);
    return (a == 8'h15) ? (d & 8'h07) : ((a == 8'h00) ? 8'h00 : (d & 8'h03));
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Read data lands one edge after the read edge
  task automatic rreg(logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Bounded poll of the state register
  task automatic wait_st(logic [7:0] st, int n);
    for (int i = 0; i < n; i++) begin
      rreg(8'h1E);
      if (rdat === st) return;
    end
    chk("state wait", rdat, st);
    complete_run();
  endtask
  initial begin
    v = $urandom(32'hD4C33391);
    sc = v[3:0];
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sv <= 1'b1;
    @(posedge clk);
    // Valid left high with a new code: later results must be ignored
    sc <= ~sc;
    @(posedge clk) #1;
    chk("strap", {3'h0, stp}, {4'h1, v[3:0]});
    foreach (ofs[i]) begin
      rreg(ofs[i]);
      chk("reset value", rdat, dfl[i]);
      v = $urandom;
      wreg(ofs[i], v);
      rreg(ofs[i]);
      chk("readback", rdat, fld(ofs[i], v));
    end
    for (int i = 0; i < 3; i++) wreg(ofs[i], 8'h00);
    en <= 1'b1;
    wait_st(8'h02, 5);
    chk("run drive", {3'h0, drv}, 8'h0B);
    // Start-up pulses: one cycle on, three off, low side complementary
    pwm <= 1'b1;
    minp <= 1'b1;
    repeat (6) @(posedge clk);
    repeat (8) @(posedge clk) #1 n += drv.hs_on;
    chk("min pulses", 8'(n), 8'h02);
    chk("complement", {7'h0, drv.hs_on ^ drv.ls_on}, 8'h01);
    pwm <= 1'b0;
    minp <= 1'b0;
    repeat (3) @(posedge clk);
    // Short: drain on low side, then hiccup with both off, then retry
    shrt <= 1'b1;
    repeat (2) @(posedge clk);
    shrt <= 1'b0;
    wait_st(8'h04, 4);
    chk("oc drive", {3'h0, drv}, 8'h0D);
    wait_st(8'h08, 10);
    repeat (12) @(posedge clk) #1;
    chk("hiccup gates", {6'h0, drv[4:3]}, 8'h00);
    wait_st(8'h02, 10);
    chk("retry drive", {3'h0, drv}, 8'h0B);
    // Feedback at 106 percent against the 105 percent level
    fb <= 8'h6A;
    repeat (100) @(posedge clk);
    rreg(8'h1E);
    chk("ov qualify", rdat, 8'h02);
    wait_st(8'h10, 20);
    chk("ov drive", {5'h0, drv[4:3], drv[1]}, 8'h02);
    fb <= 8'h63;
    repeat (5) @(posedge clk) #1;
    chk("ov discharge end", {6'h0, drv[4:3]}, 8'h00);
    rreg(8'h1E);
    chk("ov latch hold", rdat, 8'h10);
    en <= 1'b0;
    wait_st(8'h01, 5);
    en <= 1'b1;
    wait_st(8'h02, 5);
    // Over-temperature at 76 C against 75 C, restart at 55 C
    tmp <= 8'h4C;
    wait_st(8'h20, 5);
    chk("ot drive", {3'h0, drv}, 8'h05);
    tmp <= 8'h38;
    repeat (5) @(posedge clk);
    rreg(8'h1E);
    chk("ot hold", rdat, 8'h20);
    tmp <= 8'h37;
    wait_st(8'h02, 5);
    complete_run();
  end
endmodule
